// *** design/vsp_pkg.sv ***
package vsp_pkg;

  // ****************************************
  // Register map (index; byte address is index * 4)
  // ****************************************
  localparam int          ADDR_W         = 12;
  localparam int          IDX_W          = 8;
  localparam logic [7:0]  IDX_SOG_CTRL   = 8'h0f;
  localparam logic [7:0]  IDX_SYNC_CTRL  = 8'h10;
  localparam logic [7:0]  IDX_PIPE_CTRL  = 8'h11;
  localparam logic [7:0]  IDX_HS_POS     = 8'h12;
  localparam logic [7:0]  IDX_HS_WIDTH   = 8'h13;
  localparam logic [7:0]  IDX_STATUS     = 8'h14;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int          SOG_THR_MSB    = 7;
  localparam int          SOG_THR_LSB    = 3;
  localparam int          OVR_BIT        = 2;
  localparam int          SEL_BIT        = 1;
  localparam int          HS_POL_BIT     = 6;
  localparam int          VS_POL_BIT     = 2;
  localparam int          PHASE_LSB      = 0;
  localparam int          PHASE_W        = 2;
  localparam int          SOG_SRC_BIT    = 4;
  localparam int          VS_SRC_BIT     = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  SOG_CTRL_RST   = 8'h80;
  localparam logic [7:0]  SYNC_CTRL_RST  = 8'h00;
  localparam logic [7:0]  PIPE_CTRL_RST  = 8'h00;
  localparam logic [7:0]  HS_POS_RST     = 8'h00;
  localparam logic [7:0]  HS_WIDTH_RST   = 8'h10;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_PERIOD_NS  = 25;
  localparam int          VSEP_MIN_NS    = 4000;
  localparam int          VSEP_CYC       = (VSEP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PHASE_DEPTH    = 4;
  localparam int          HCNT_W         = 9;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } vsp_rgb_s;

  typedef struct packed {
    vsp_rgb_s rgb;
    logic     hs;
    logic     vs;
  } vsp_pixel_s;

  typedef struct packed {
    vsp_rgb_s rgb;
    logic     hs;
    logic     ck;
  } vsp_tap_s;

  typedef enum logic [1:0] {
    INTF_NONE    = 2'b00,
    INTF_ANALOG  = 2'b01,
    INTF_DIGITAL = 2'b11
  } vsp_intf_e;

endpackage

// *** design/vsp_output_stage.sv ***
// Notes on behaviour
// - Recovered hsync output is rebuilt from input hsync, aligned with pixel clock.
// - Hsync position and width registers accept writes only in analog mode.
// - In digital mode hsync passes with transmitter placement and width untouched.
// - A control bit sets recovered hsync output polarity.
// - Vertical sync comes from composite separator or direct vsync passthrough.
// - Bit 2 of register 0x10 inverts vertical sync output.
// - Bit 6 of register 0x10 sets input hsync sense.
// - Polarity 0 makes falling edge leading; polarity 1 makes rising edge leading.
// - Leading edge feeds pixel loop reference; trailing edge times the clamp.
// - Register 0x0F bits 7 to 3 set green slicer threshold.
// - Slicer result appears on green sync output without inversion.
// - Software picks slicer result or delayed raw hsync for green sync output.
// - Composite sync reaches green sync output with no further processing.
// - Shared 8-bit colour outputs, bit 7 MSB, follow the active interface.
// - One shared pixel data clock output follows the active interface.
// - Analog mode clock output derives from the pixel sampling clock.
// - Latency from sampling instant to outputs grows by one system clock per phase step (phase 0 to 3).
// - Phase change moves data, clock and hsync together.
// - Override bit forces interface chosen by select bit: 0 analog, 1 digital.
`timescale 1ns/1ps
`default_nettype none

module vsp_output_stage
  import vsp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              resetn_i,
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // Analog side
  input  wire logic              analog_clk_i,
  input  wire vsp_pixel_s        analog_pixel_i,
  input  wire logic [7:0]        green_embedded_sync_in_i,
  input  wire logic              analog_detect_i,
  // Digital side
  input  wire logic              digital_clk_i,
  input  wire vsp_pixel_s        digital_pixel_i,
  input  wire logic              digital_detect_i,
  // Outputs to display controller
  output vsp_rgb_s               rgb_o,
  output logic                   pixel_data_clock_out_o,
  output logic                   recovered_hsync_out_o,
  output logic                   vertical_sync_out_o,
  output logic                   green_sync_slicer_out_o,
  output logic                   pll_ref_o,
  output logic                   clamp_o,
  output logic [1:0]             active_intf_o
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int PIX_W = $bits(vsp_pixel_s);
  localparam int SYN_W = 4 + 2 * PIX_W + 8;

  logic [SYN_W-1:0] async_in;
  logic [SYN_W-1:0] meta_q;
  logic [SYN_W-1:0] sync_q;

  assign async_in = {analog_clk_i, digital_clk_i, analog_detect_i, digital_detect_i,
                     analog_pixel_i, digital_pixel_i, green_embedded_sync_in_i};

  genvar gi;
  generate
    for (gi = 0; gi < SYN_W; gi++) begin : g_sync
      always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= async_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  logic       a_clk;
  logic       d_clk;
  logic       a_det;
  logic       d_det;
  vsp_pixel_s a_pix;
  vsp_pixel_s d_pix;
  logic [7:0] sog_lvl;

  assign {a_clk, d_clk, a_det, d_det, a_pix, d_pix, sog_lvl} = sync_q;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] sog_ctrl_q;
  logic [7:0] sync_ctrl_q;
  logic [7:0] pipe_ctrl_q;
  logic [7:0] hs_pos_q;
  logic [7:0] hs_width_q;
  vsp_intf_e  intf_q;
  vsp_intf_e  intf_d;
  logic       sep_vs;

  logic [IDX_W-1:0] idx;
  logic             mapped;
  logic             acc;
  logic             wr;

  assign idx    = paddr_i[IDX_W+1:2];
  assign acc    = psel_i & penable_i;
  assign wr     = acc & pwrite_i & mapped;

  always_comb begin
    mapped = 1'b0;
    if (paddr_i[1:0] != 2'b00 || paddr_i[ADDR_W-1:IDX_W+2] != '0) begin
      mapped = 1'b0;
    end else if (idx == IDX_SOG_CTRL) begin
      mapped = 1'b1;
    end else if (idx == IDX_SYNC_CTRL) begin
      mapped = 1'b1;
    end else if (idx == IDX_PIPE_CTRL) begin
      mapped = 1'b1;
    end else if (idx == IDX_HS_POS) begin
      mapped = 1'b1;
    end else if (idx == IDX_HS_WIDTH) begin
      mapped = 1'b1;
    end else if (idx == IDX_STATUS) begin
      mapped = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sog_ctrl_q  <= SOG_CTRL_RST;
      sync_ctrl_q <= SYNC_CTRL_RST;
      pipe_ctrl_q <= PIPE_CTRL_RST;
      hs_pos_q    <= HS_POS_RST;
      hs_width_q  <= HS_WIDTH_RST;
    end else if (wr) begin
      if (idx == IDX_SOG_CTRL) begin
        sog_ctrl_q <= pwdata_i[7:0];
      end else if (idx == IDX_SYNC_CTRL) begin
        sync_ctrl_q <= pwdata_i[7:0];
      end else if (idx == IDX_PIPE_CTRL) begin
        pipe_ctrl_q <= pwdata_i[7:0];
      end else if (idx == IDX_HS_POS && intf_q == INTF_ANALOG) begin
        hs_pos_q <= pwdata_i[7:0];
      end else if (idx == IDX_HS_WIDTH && intf_q == INTF_ANALOG) begin
        hs_width_q <= pwdata_i[7:0];
      end
    end
  end

  always_comb begin
    prdata_o = 32'h0000_0000;
    if (acc && !pwrite_i && mapped) begin
      if (idx == IDX_SOG_CTRL) begin
        prdata_o[7:0] = sog_ctrl_q;
      end else if (idx == IDX_SYNC_CTRL) begin
        prdata_o[7:0] = sync_ctrl_q;
      end else if (idx == IDX_PIPE_CTRL) begin
        prdata_o[7:0] = pipe_ctrl_q;
      end else if (idx == IDX_HS_POS) begin
        prdata_o[7:0] = hs_pos_q;
      end else if (idx == IDX_HS_WIDTH) begin
        prdata_o[7:0] = hs_width_q;
      end else begin
        prdata_o[4:0] = {sep_vs, d_det, a_det, intf_q};
      end
    end
  end

  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~mapped;

  // ****************************************
  // Active interface
  // ****************************************
  logic ovr;
  logic sel;

  assign ovr = sog_ctrl_q[OVR_BIT];
  assign sel = sog_ctrl_q[SEL_BIT];

  always_comb begin
    intf_d = INTF_NONE;
    if (ovr) begin
      intf_d = sel ? INTF_DIGITAL : INTF_ANALOG;
    end else if (a_det && d_det) begin
      intf_d = sel ? INTF_DIGITAL : INTF_ANALOG;
    end else if (a_det) begin
      intf_d = INTF_ANALOG;
    end else if (d_det) begin
      intf_d = INTF_DIGITAL;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      intf_q <= INTF_NONE;
    end else begin
      intf_q <= intf_d;
    end
  end

  logic is_analog;
  logic is_digital;

  assign is_analog  = (intf_q == INTF_ANALOG);
  assign is_digital = (intf_q == INTF_DIGITAL);

  // ****************************************
  // Hsync edges
  // ****************************************
  logic hs_act;
  logic hs_act_q;
  logic lead;
  logic trail;

  assign hs_act = sync_ctrl_q[HS_POL_BIT] ? a_pix.hs : ~a_pix.hs;
  assign lead   = hs_act & ~hs_act_q;
  assign trail  = ~hs_act & hs_act_q;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hs_act_q  <= 1'b0;
      pll_ref_o <= 1'b0;
      clamp_o   <= 1'b0;
    end else begin
      hs_act_q  <= hs_act;
      pll_ref_o <= lead & is_analog;
      clamp_o   <= trail & is_analog;
    end
  end

  // ****************************************
  // Pixel clock select and sampling
  // ****************************************
  logic       src_clk;
  logic       src_clk_q;
  logic       pix_edge;
  vsp_pixel_s src_pix;

  assign src_clk  = is_digital ? d_clk : (is_analog & a_clk);
  assign src_pix  = is_digital ? d_pix : a_pix;
  assign pix_edge = src_clk & ~src_clk_q;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      src_clk_q <= 1'b0;
    end else begin
      src_clk_q <= src_clk;
    end
  end

  // Hsync rebuild counter, in pixel clocks from leading edge
  logic [HCNT_W-1:0] hcnt_q;
  logic [HCNT_W-1:0] hs_end;
  logic              hs_gen;

  assign hs_end = HCNT_W'(hs_pos_q) + HCNT_W'(hs_width_q);

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hcnt_q <= '1;
    end else if (lead) begin
      hcnt_q <= '0;
    end else if (pix_edge && hcnt_q != '1) begin
      hcnt_q <= hcnt_q + HCNT_W'(1);
    end
  end

  always_comb begin
    hs_gen = 1'b0;
    if (is_digital) begin
      hs_gen = d_pix.hs;
    end else if (is_analog) begin
      hs_gen = (hcnt_q >= HCNT_W'(hs_pos_q)) && (hcnt_q < hs_end);
    end
  end

  vsp_rgb_s cap_rgb_q;
  logic     cap_hs_q;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cap_rgb_q <= '0;
      cap_hs_q  <= 1'b0;
    end else if (pix_edge) begin
      cap_rgb_q <= src_pix.rgb;
      cap_hs_q  <= hs_gen;
    end
  end

  // ****************************************
  // Phase delay line
  // ****************************************
  vsp_tap_s tap_q [PHASE_DEPTH];

  generate
    for (gi = 0; gi < PHASE_DEPTH; gi++) begin : g_tap
      always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
          tap_q[gi] <= '0;
        end else if (gi == 0) begin
          tap_q[gi] <= '{rgb: cap_rgb_q, hs: cap_hs_q, ck: src_clk_q};
        end else begin
          tap_q[gi] <= tap_q[(gi == 0) ? 0 : gi - 1];
        end
      end
    end
  endgenerate

  logic [PHASE_W-1:0] phase;
  vsp_tap_s           tap_sel;

  assign phase   = pipe_ctrl_q[PHASE_LSB +: PHASE_W];
  assign tap_sel = tap_q[phase];

  // ****************************************
  // Green slicer and vertical sync
  // ****************************************
  logic                   slicer;
  logic                   sog_sig;
  logic [7:0]             vsep_q;
  logic [PHASE_DEPTH-1:0] raw_hs_q;

  // Delayed raw hsync input, no polarity or rebuild
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      raw_hs_q <= '0;
    end else begin
      raw_hs_q <= {raw_hs_q[PHASE_DEPTH-2:0], a_pix.hs};
    end
  end

  assign slicer  = sog_lvl[7:3] >= sog_ctrl_q[SOG_THR_MSB:SOG_THR_LSB];
  assign sog_sig = pipe_ctrl_q[SOG_SRC_BIT] ? raw_hs_q[PHASE_DEPTH-1] : slicer;
  assign sep_vs  = (vsep_q >= 8'(VSEP_CYC));

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vsep_q <= 8'h00;
    end else if (sog_sig) begin
      vsep_q <= 8'h00;
    end else if (!sep_vs) begin
      vsep_q <= vsep_q + 8'h01;
    end
  end

  logic vs_src;

  assign vs_src = pipe_ctrl_q[VS_SRC_BIT] ? sep_vs : src_pix.vs;

  // ****************************************
  // Output registers
  // ****************************************
  logic on;

  assign on = is_analog | is_digital;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rgb_o                   <= '0;
      pixel_data_clock_out_o  <= 1'b0;
      recovered_hsync_out_o   <= 1'b0;
      vertical_sync_out_o     <= 1'b0;
      green_sync_slicer_out_o <= 1'b0;
      active_intf_o           <= INTF_NONE;
    end else begin
      rgb_o                   <= on ? tap_sel.rgb : '0;
      pixel_data_clock_out_o  <= on & tap_sel.ck;
      recovered_hsync_out_o   <= (on & tap_sel.hs) ^ sync_ctrl_q[HS_POL_BIT - 1];
      vertical_sync_out_o     <= (on & vs_src) ^ sync_ctrl_q[VS_POL_BIT];
      green_sync_slicer_out_o <= sog_sig;
      active_intf_o           <= intf_q;
    end
  end

endmodule

`default_nettype wire

// *** design/unused_placeholder_note.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** tb/vsp_output_stage_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module vsp_output_stage_chk
  import vsp_pkg::*;
(
  // Clock and reset
  input wire logic       clk_sys_i,
  input wire logic       resetn_i,
  // Watched outputs
  input wire vsp_rgb_s   rgb_o,
  input wire logic       pixel_data_clock_out_o,
  input wire logic       pll_ref_o,
  input wire logic       clamp_o,
  input wire logic [1:0] active_intf_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  property p_ref_pulse; pll_ref_o |=> !pll_ref_o; endproperty
  a_ref_pulse: assert property (p_ref_pulse)
    else $error("loop reference pulse too long");
  property p_clamp_pulse; clamp_o |=> !clamp_o; endproperty
  a_clamp_pulse: assert property (p_clamp_pulse)
    else $error("clamp pulse too long");
  property p_edge_excl; !(pll_ref_o && clamp_o); endproperty
  a_edge_excl: assert property (p_edge_excl)
    else $error("leading and trailing pulses together");
  property p_edge_analog;
    (pll_ref_o || clamp_o) |->
      (active_intf_o == INTF_ANALOG || $past(active_intf_o) == INTF_ANALOG);
  endproperty
  a_edge_analog: assert property (p_edge_analog)
    else $error("edge pulse outside analog mode");
  property p_intf_code; active_intf_o != 2'b10; endproperty
  a_intf_code: assert property (p_intf_code)
    else $error("illegal interface code");
  property p_idle_zero;
    (active_intf_o == INTF_NONE)[*8] |-> (rgb_o == '0 && !pixel_data_clock_out_o);
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("outputs active with no interface");
  property p_clk_high; $rose(pixel_data_clock_out_o) |=> pixel_data_clock_out_o; endproperty
  a_clk_high: assert property (p_clk_high)
    else $error("data clock high phase too short");
  property p_data_stand;
    $changed(rgb_o) && active_intf_o != INTF_NONE && $past(active_intf_o, 4) == active_intf_o
      |=> $stable(rgb_o)[*2];
  endproperty
  a_data_stand: assert property (p_data_stand)
    else $error("colour data changed too soon");
endmodule
`default_nettype wire

// *** tb/vsp_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module vsp_far_end
  import vsp_pkg::*;
(
  // Clock and reset
  input  wire logic    clk_sys_i,
  input  wire logic    resetn_i,
  // From the output stage
  input  wire logic    pixel_data_clock_i,
  input  wire vsp_rgb_s rgb_i,
  input  wire logic    hsync_i,
  // Captured values
  output var vsp_rgb_s cap_rgb_o,
  output logic         cap_hs_o,
  output logic [15:0]  cap_cnt_o
);
  logic ck_q;
  // Capture on data clock rise
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ck_q      <= 1'b0;
      cap_rgb_o <= '0;
      cap_hs_o  <= 1'b0;
      cap_cnt_o <= '0;
    end else begin
      ck_q <= pixel_data_clock_i;
      if (pixel_data_clock_i && !ck_q) begin
        cap_rgb_o <= rgb_i;
        cap_hs_o  <= hsync_i;
        cap_cnt_o <= cap_cnt_o + 16'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/vsp_output_stage_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module vsp_output_stage_tb;
  import vsp_pkg::*;
  // ****************
  // Signals
  // ****************
  logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        a_clk = 1'b0, d_clk = 1'b0, a_det = 1'b0, d_det = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [7:0]  green = '0;
  vsp_pixel_s  a_pix = '0, d_pix = '0;
  logic [31:0] prdata, rd;
  logic        pready, perr, err, pdc, hs_out, vs_out, sog, pll_ref, clamp, cap_hs;
  logic [1:0]  intf;
  vsp_rgb_s    rgb, cap_rgb;
  logic [15:0] cap_cnt, cnt0;
  int          fails = 0, tests_run = 0;
  logic [7:0]  sel_v [7] = '{8'h80, 8'h84, 8'h86, 8'h80, 8'h80, 8'h80, 8'h82};
  logic [1:0]  det_v [7] = '{2'b00, 2'b11, 2'b11, 2'b01, 2'b10, 2'b11, 2'b11};
  logic [1:0]  exp_v [7] = '{2'b00, 2'b01, 2'b11, 2'b01, 2'b11, 2'b01, 2'b11};
  logic [7:0]  rst_v [5] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h10};
  logic [7:0]  sgc_v [4] = '{8'h84, 8'h84, 8'h84, 8'h7c};
  logic [7:0]  grn_v [4] = '{8'hff, 8'h7f, 8'h80, 8'h7f};
  logic        sog_v [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  vsp_output_stage u_dut (
    .clk_sys_i(clk), .resetn_i(rstn), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(perr), .analog_clk_i(a_clk), .analog_pixel_i(a_pix),
    .green_embedded_sync_in_i(green), .analog_detect_i(a_det), .digital_clk_i(d_clk),
    .digital_pixel_i(d_pix), .digital_detect_i(d_det), .rgb_o(rgb),
    .pixel_data_clock_out_o(pdc), .recovered_hsync_out_o(hs_out),
    .vertical_sync_out_o(vs_out), .green_sync_slicer_out_o(sog), .pll_ref_o(pll_ref),
    .clamp_o(clamp), .active_intf_o(intf)
  );
  vsp_far_end u_far (
    .clk_sys_i(clk), .resetn_i(rstn), .pixel_data_clock_i(pdc), .rgb_i(rgb),
    .hsync_i(hs_out), .cap_rgb_o(cap_rgb), .cap_hs_o(cap_hs), .cap_cnt_o(cap_cnt)
  );
  initial begin
    forever #12.5 clk = ~clk;
  end
  // ****************
  // Tasks
  // ****************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (fails == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int k = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      fails++;
      report_and_stop();
    end
    rd   = prdata;
    err  = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(nm, rd, exp);
  endtask
  task automatic px(input int n);
    repeat (n) begin
      @(posedge clk);
      a_clk <= 1'b1;
      d_clk <= 1'b1;
      wt(4);
      a_clk <= 1'b0;
      d_clk <= 1'b0;
      wt(3);
    end
    wt(12);
  endtask
  task automatic hs_edge(input logic v, input logic ep, input logic ec);
    logic sp = 1'b0;
    logic sc = 1'b0;
    @(posedge clk);
    a_pix.hs <= v;
    repeat (8) begin
      @(posedge clk);
      sp = sp | pll_ref;
      sc = sc | clamp;
    end
    chk("pll_ref", {31'h0, sp}, {31'h0, ep});
    chk("clamp", {31'h0, sc}, {31'h0, ec});
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    wt(20);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd_chk("reset_value", IDX_SOG_CTRL + 8'(i), {24'h0, rst_v[i]});
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    for (int i = 0; i < 7; i++) begin
      d_det <= det_v[i][1];
      a_det <= det_v[i][0];
      wr(IDX_SOG_CTRL, {24'h0, sel_v[i]});
      wt(6);
      chk("active_intf", {30'h0, intf}, {30'h0, exp_v[i]});
    end
    wr(IDX_HS_WIDTH, 32'h22);
    rd_chk("hs_width", IDX_HS_WIDTH, 32'h10);
    d_pix <= {24'h8001ff, 1'b1, 1'b0};
    px(4);
    chk("rgb", {8'h0, rgb}, 32'h8001ff);
    chk("cap_rgb", {8'h0, cap_rgb}, 32'h8001ff);
    chk("cap_hs", {31'h0, cap_hs}, 32'h1);
    chk("vs", {31'h0, vs_out}, 32'h0);
    wr(IDX_SYNC_CTRL, 32'h24);
    wt(4);
    chk("hs_inv", {31'h0, hs_out}, 32'h0);
    chk("vs_inv", {31'h0, vs_out}, 32'h1);
    d_pix.vs <= 1'b1;
    px(2);
    chk("vs_pass", {31'h0, vs_out}, 32'h0);
    wr(IDX_SYNC_CTRL, 32'h0);
    wr(IDX_SOG_CTRL, 32'h84);
    wt(6);
    wr(IDX_HS_WIDTH, 32'h22);
    rd_chk("hs_width", IDX_HS_WIDTH, 32'h22);
    a_pix <= {24'h7fc301, 1'b0, 1'b0};
    px(4);
    chk("rgb", {8'h0, rgb}, 32'h7fc301);
    wr(IDX_PIPE_CTRL, 32'h3);
    cnt0 = cap_cnt;
    px(4);
    chk("cap_cnt", {16'h0, cap_cnt - cnt0}, 32'h4);
    chk("cap_rgb", {8'h0, cap_rgb}, 32'h7fc301);
    hs_edge(1'b1, 1'b0, 1'b1);
    hs_edge(1'b0, 1'b1, 1'b0);
    wr(IDX_SYNC_CTRL, 32'h40);
    wt(8);
    hs_edge(1'b1, 1'b1, 1'b0);
    hs_edge(1'b0, 1'b0, 1'b1);
    wr(IDX_SYNC_CTRL, 32'h0);
    wt(8);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_SOG_CTRL, {24'h0, sgc_v[i]});
      green <= grn_v[i];
      wt(6);
      chk("sog", {31'h0, sog}, {31'h0, sog_v[i]});
    end
    wr(IDX_PIPE_CTRL, 32'h13);
    a_pix.hs <= 1'b1;
    wt(10);
    chk("sog_hs", {31'h0, sog}, 32'h1);
    a_pix.hs <= 1'b0;
    wt(10);
    chk("sog_hs", {31'h0, sog}, 32'h0);
    wr(IDX_PIPE_CTRL, 32'h33);
    wt(20);
    chk("vs_sep", {31'h0, vs_out}, 32'h0);
    wt(170);
    chk("vs_sep", {31'h0, vs_out}, 32'h1);
    rd_chk("status", IDX_STATUS, 32'h1d);
    a_pix.hs <= 1'b1;
    wt(10);
    chk("vs_sep", {31'h0, vs_out}, 32'h0);
    report_and_stop();
  end
endmodule
bind vsp_output_stage vsp_output_stage_chk u_chk (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .rgb_o(rgb_o),
  .pixel_data_clock_out_o(pixel_data_clock_out_o), .pll_ref_o(pll_ref_o),
  .clamp_o(clamp_o), .active_intf_o(active_intf_o)
);
`default_nettype wire
